// File: bpc_consts.svh
// bpc_consts.svh: register map, field positions, reset values and timing
// of the boost converter protection control.
// assumes: included by bare name; the clock runs at BPC_CLK_MHZ.
`ifndef BPC_CONSTS_SVH
`define BPC_CONSTS_SVH

// ==========================================================================
// register offsets
`define BPC_ADDR_STATUS   8'h02
`define BPC_ADDR_CTRL     8'h03

// ==========================================================================
// status/config register fields
`define BPC_ST_OC_FLAG    0
`define BPC_ST_OC_ON      1
`define BPC_ST_OV_FLAG    2
`define BPC_ST_OV_ON      3
`define BPC_ST_FREQ       4
`define BPC_ST_RATE_LO    5
`define BPC_ST_RATE_HI    6
`define BPC_ST_RESET      8'h0A

// ==========================================================================
// control register fields
`define BPC_CT_MANUAL     0
`define BPC_CT_MANUAL_RECOVER_CMD       1
`define BPC_CT_EN         2
`define BPC_CT_MB_ON      3
`define BPC_CT_MBV_LO     4
`define BPC_CT_MBV_HI     7
`define BPC_CT_RESET      8'h00

// ==========================================================================
// timing
`define BPC_CLK_MHZ       20
`define BPC_FILT_TIME_US  1200
`define BPC_REC_TIME_US   20000
`define BPC_SS_STEP_US    50
`define BPC_SS_STEPS      16

`endif

// File: bpc_pkg.sv
// bpc_pkg.sv: types of the boost converter protection control.
// assumes: nothing beyond a SystemVerilog compiler.
package bpc_pkg;

   // =======================================================================
   // converter sequencer states
   typedef enum logic [1:0] {
      ST_OFF   = 2'b00,
      ST_SOFT  = 2'b01,
      ST_RUN   = 2'b10,
      ST_FAULT = 2'b11
   } bpc_state_t;

endpackage

// File: bpc_chan_if.sv
// bpc_chan_if.sv: carrier between the sequencer and one protection channel.
// assumes: one instance per protection circuit.
`timescale 1ns/100ps
interface bpc_chan_if;
   logic cond;        // synchronised comparator level
   logic protect_on;  // protection enable bit
   logic active;      // condition present and protection enabled
   logic trip;        // one-cycle pulse: condition held for the window

   // =======================================================================
   // views
   modport chan (input cond, input protect_on, output active, output trip);
   modport ctrl (output cond, output protect_on, input active, input trip);
endinterface

// File: bpc_prot_chan.sv
// bpc_prot_chan.sv: persistence timer of one protection circuit.
// assumes: ch.cond is already synchronised to clk.
`timescale 1ns/100ps
module bpc_prot_chan
   import bpc_pkg::*;
#(
   parameter int FILT_CYC = 24000
)(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // sequencer side
   bpc_chan_if.chan ch
);
   localparam int CW = $clog2(FILT_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(FILT_CYC - 1);
   localparam logic [CW-1:0] FULL = CW'(FILT_CYC);

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   wire           armed;

   // =======================================================================
   // disabled protection never counts nor trips
   assign armed     = ch.cond & ch.protect_on;
   assign ch.active = armed;
   // trip once the condition has held without a break for the window
   assign ch.trip   = armed && (cnt_r == LAST);
   assign cnt_nxt   = !armed ? '0 :
                      (cnt_r == FULL) ? cnt_r : cnt_r + CW'(1);

   // counter restarts on any gap in the condition
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule // bpc_prot_chan

// File: bpc_boost_ctrl.sv
// bpc_boost_ctrl.sv: boost converter enable, soft start, overcurrent and
// overvoltage protection, fault flags and recovery.
// assumes: comparator inputs are asynchronous; register port is on clk.
//
// How it works
// - input current over limit for 1.2 ms unbroken shuts the converter.
// - shutdown latches its flag in status boost_protect_status, raises fault_irq.
// - reading status register clears overvoltage and overcurrent flags.
// - both protection enables reset to on; software should keep them.
// - control bit 0 picks automatic or manual recovery after a fault.
// - automatic recovery retries the converter 20 ms after shutdown.
// - manual recovery restarts only after software writes 1 to bit 1.
// - a condition still present at retry keeps the converter off.
// - converter is off after power-up until software enables it.
// - control bit 2 starts the converter when set, stops it when clear.
// - enabling starts a stepped soft start limiting inrush current.
// - status bit 4 selects 1.5 MHz or 3 MHz switching frequency.
`timescale 1ns/100ps
`include "bpc_consts.svh"
module bpc_boost_ctrl
   import bpc_pkg::*;
#(
   parameter int FILT_CYC = `BPC_FILT_TIME_US * `BPC_CLK_MHZ,
   parameter int REC_CYC  = `BPC_REC_TIME_US * `BPC_CLK_MHZ
)(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // register port
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   // analog comparators
   input  wire logic       oc_cmp_in,
   input  wire logic       ov_cmp_in,
   // converter and bias controls
   output logic            boost_on,
   output logic      [3:0] soft_start_lvl,
   output logic            sw_freq_sel,
   output logic      [1:0] sample_rate_sel,
   output logic            mic_bias_on,
   output logic      [3:0] mic_bias_volts,
   // fault interrupt
   output logic            fault_irq
);
   localparam int SS_CYC = `BPC_SS_STEP_US * `BPC_CLK_MHZ;
   localparam int TW     = $clog2(((REC_CYC > SS_CYC) ? REC_CYC : SS_CYC)
                                  + 1);
   localparam logic [TW-1:0] REC_LAST = TW'(REC_CYC - 1);
   localparam logic [TW-1:0] SS_LAST  = TW'(SS_CYC - 1);
   localparam logic [3:0]    SS_TOP   = 4'(`BPC_SS_STEPS - 1);
   localparam logic [7:0]    CT_WMASK = ~(8'h01 << `BPC_CT_MANUAL_RECOVER_CMD);

   // =======================================================================
   // declarations
   logic [1:0]  sync1_r;
   logic [1:0]  sync2_r;
   logic [7:0]  status_r;
   logic [7:0]  status_nxt;
   logic [7:0]  ctrl_r;
   logic [7:0]  ctrl_nxt;
   logic [7:0]  rdata_r;
   logic [7:0]  rdata_nxt;
   bpc_state_t  state_r;
   bpc_state_t  state_nxt;
   logic [TW-1:0] tmr_r;
   logic [TW-1:0] tmr_nxt;
   logic [3:0]  ss_r;
   logic [3:0]  ss_nxt;
   logic        manual_recover_cmd_pend_r;
   logic        manual_recover_cmd_pend_nxt;
   wire         wr_status;
   wire         wr_ctrl;
   wire         rd_status;
   wire         rd_ctrl;
   wire         manual_recover_cmd_pulse;
   wire         en;
   wire         manual;
   wire         trip_oc;
   wire         trip_ov;
   wire         trip_any;
   wire         cond_any;
   wire         rec_ok;
   wire         ss_step;
   wire  [1:0]  trip_vec;
   wire  [1:0]  active_vec;
   logic        boost_on_r;
   wire         boost_on_nxt;
   logic        irq_r;
   wire         irq_nxt;

   bpc_chan_if ch_if[2] ();

   // =======================================================================
   // comparator synchronisers: first stage feeds only the second
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync1_r <= 2'h0;
         sync2_r <= 2'h0;
      end else begin
         sync1_r <= {ov_cmp_in, oc_cmp_in};
         sync2_r <= sync1_r;
      end
   end

   // =======================================================================
   // protection channels: index 0 overcurrent, index 1 overvoltage
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_chan
         // enable bit of this circuit in the status register
         localparam int ON_BIT = (gi == 0) ? `BPC_ST_OC_ON : `BPC_ST_OV_ON;
         assign ch_if[gi].cond       = sync2_r[gi];
         assign ch_if[gi].protect_on = status_r[ON_BIT];
         assign trip_vec[gi]         = ch_if[gi].trip;
         assign active_vec[gi]       = ch_if[gi].active;
         bpc_prot_chan #(
            .FILT_CYC (FILT_CYC)
         ) u_chan (
            .clk    (clk),
            .resetn (resetn),
            .ch     (ch_if[gi])
         );
      end
   endgenerate

   // index 0 overcurrent, index 1 overvoltage, same handling for both
   assign trip_oc  = trip_vec[0];
   assign trip_ov  = trip_vec[1];
   assign trip_any = |trip_vec;
   assign cond_any = |active_vec;

   // =======================================================================
   // register decode
   assign wr_status  = reg_wr && (reg_addr == `BPC_ADDR_STATUS);
   assign wr_ctrl    = reg_wr && (reg_addr == `BPC_ADDR_CTRL);
   assign rd_status  = reg_rd && (reg_addr == `BPC_ADDR_STATUS);
   assign rd_ctrl    = reg_rd && (reg_addr == `BPC_ADDR_CTRL);
   assign manual_recover_cmd_pulse = wr_ctrl && reg_wdata[`BPC_CT_MANUAL_RECOVER_CMD];
   assign en         = ctrl_r[`BPC_CT_EN];
   assign manual     = ctrl_r[`BPC_CT_MANUAL];

   // status/config: flags read only, set wins over clear on read
   always_comb begin
      status_nxt = status_r;
      // only enables, frequency and rate are writable
      if (wr_status) begin
         status_nxt[`BPC_ST_OC_ON] = reg_wdata[`BPC_ST_OC_ON];
         status_nxt[`BPC_ST_OV_ON] = reg_wdata[`BPC_ST_OV_ON];
         status_nxt[`BPC_ST_FREQ]  = reg_wdata[`BPC_ST_FREQ];
         status_nxt[`BPC_ST_RATE_HI:`BPC_ST_RATE_LO] =
            reg_wdata[`BPC_ST_RATE_HI:`BPC_ST_RATE_LO];
      end
      // read clears both flags; a trip in the same cycle wins below
      if (rd_status) begin
         status_nxt[`BPC_ST_OC_FLAG] = 1'b0;
         status_nxt[`BPC_ST_OV_FLAG] = 1'b0;
      end
      if (trip_oc) begin
         status_nxt[`BPC_ST_OC_FLAG] = 1'b1;
      end
      if (trip_ov) begin
         status_nxt[`BPC_ST_OV_FLAG] = 1'b1;
      end
      status_nxt[7] = 1'b0;
   end

   // control: manual recover command is a strobe and never stored in ctrl_r
   assign ctrl_nxt = wr_ctrl ? (reg_wdata & CT_WMASK) : ctrl_r;

   // read data, unmapped offsets read zero
   assign rdata_nxt = rd_status ? status_r :
                      rd_ctrl   ? ctrl_r   : 8'h00;

   // =======================================================================
   // sequencer
   assign ss_step = (tmr_r == SS_LAST);
   assign rec_ok  = manual ? (manual_recover_cmd_pend_r | manual_recover_cmd_pulse)
                           : (tmr_r == REC_LAST);

   always_comb begin
      state_nxt     = state_r;
      tmr_nxt       = '0;
      ss_nxt        = 4'h0;
      manual_recover_cmd_pend_nxt = 1'b0;
      case (state_r)
         ST_OFF: begin
            if (en) begin
               state_nxt = ST_SOFT;
            end
         end
         ST_SOFT: begin
            // step the level every soft start interval
            tmr_nxt = ss_step ? '0 : tmr_r + TW'(1);
            ss_nxt  = (ss_step && ss_r != SS_TOP) ? ss_r + 4'h1 : ss_r;
            if (!en) begin
               state_nxt = ST_OFF;
               tmr_nxt   = '0;
            end else if (trip_any) begin
               state_nxt = ST_FAULT;
               tmr_nxt   = '0;  // recovery delay counts from shutdown
            end else if (ss_step && ss_r == SS_TOP) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            ss_nxt = SS_TOP;
            if (!en) begin
               state_nxt = ST_OFF;
            end else if (trip_any) begin
               state_nxt = ST_FAULT;
            end
         end
         ST_FAULT: begin
            // auto waits out the timer, manual waits for the strobe
            tmr_nxt       = (tmr_r == REC_LAST) ? tmr_r : tmr_r + TW'(1);
            manual_recover_cmd_pend_nxt = manual & (manual_recover_cmd_pend_r | manual_recover_cmd_pulse);
            if (!en) begin
               state_nxt = ST_OFF;
            end else if (rec_ok && !cond_any) begin
               state_nxt     = ST_SOFT;
               tmr_nxt       = '0;
               manual_recover_cmd_pend_nxt = 1'b0;
            end
         end
         default: begin
            state_nxt = ST_OFF;
         end
      endcase
   end

   // =======================================================================
   // register file: status/config and control
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         status_r <= `BPC_ST_RESET;
         ctrl_r   <= `BPC_CT_RESET;
      end else begin
         status_r <= status_nxt;
         ctrl_r   <= ctrl_nxt;
      end
   end

   // read data holds until the next edge
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // =======================================================================
   // sequencer registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r     <= ST_OFF;
         manual_recover_cmd_pend_r <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         manual_recover_cmd_pend_r <= manual_recover_cmd_pend_nxt;
      end
   end

   // shared delay timer and soft start step
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tmr_r <= '0;
         ss_r  <= 4'h0;
      end else begin
         tmr_r <= tmr_nxt;
         ss_r  <= ss_nxt;
      end
   end

   // =======================================================================
   // output flops: run and fault lines change without decode glitches
   assign boost_on_nxt = (state_nxt == ST_SOFT) || (state_nxt == ST_RUN);
   assign irq_nxt      = status_nxt[`BPC_ST_OC_FLAG] |
                         status_nxt[`BPC_ST_OV_FLAG];

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         boost_on_r <= 1'b0;
         irq_r      <= 1'b0;
      end else begin
         boost_on_r <= boost_on_nxt;
         irq_r      <= irq_nxt;
      end
   end

   // =======================================================================
   // outputs
   assign reg_rdata       = rdata_r;
   assign boost_on        = boost_on_r;
   assign soft_start_lvl  = ss_r;
   assign sw_freq_sel     = status_r[`BPC_ST_FREQ];
   assign sample_rate_sel = status_r[`BPC_ST_RATE_HI:`BPC_ST_RATE_LO];
   assign mic_bias_on     = ctrl_r[`BPC_CT_MB_ON];
   assign mic_bias_volts  = ctrl_r[`BPC_CT_MBV_HI:`BPC_CT_MBV_LO];
   assign fault_irq       = irq_r;
endmodule // bpc_boost_ctrl

// File: bpc_boost_ctrl_asserts.sv
// bpc_boost_ctrl_asserts.sv: port checks of the boost converter control.
// assumes: bound into bpc_boost_ctrl; one clock domain.
`timescale 1ns/100ps
module bpc_boost_ctrl_asserts #(
   parameter int FILT_CYC = 24000
)(
   // clock and reset
   input wire logic       clk,
   input wire logic       resetn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // comparators and converter
   input wire logic       oc_cmp_in,
   input wire logic       ov_cmp_in,
   input wire logic       boost_on,
   input wire logic [3:0] soft_start_lvl,
   input wire logic       sw_freq_sel,
   input wire logic [1:0] sample_rate_sel,
   input wire logic       fault_irq
);
   // ======================================================================
   // shadows of enables, overcurrent persistence count
   logic        oc_on_r;
   logic        en_r;
   logic [31:0] run_r;
   wire         rd_st = reg_rd && reg_addr == 8'h02;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         oc_on_r <= 1'b1;
         en_r    <= 1'b0;
         run_r   <= '0;
      end else begin
         if (reg_wr && reg_addr == 8'h02) oc_on_r <= reg_wdata[1];
         if (reg_wr && reg_addr == 8'h03) en_r <= reg_wdata[2];
         run_r <= (oc_cmp_in && oc_on_r) ? run_r + 1 : '0;
      end
   end
   // ======================================================================
   // properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_quiet;
      (!oc_cmp_in && !ov_cmp_in) [*5];
   endsequence
   sequence s_ramp;
      (soft_start_lvl == 4'h0) [*8];
   endsequence
   property p_trip; run_r >= FILT_CYC + 6 |-> !boost_on; endproperty
   property p_shut; $rose(fault_irq) |-> !boost_on; endproperty
   property p_map;
      reg_rd && !(reg_addr inside {8'h02, 8'h03}) |=> reg_rdata == 8'h00;
   endproperty
   property p_flag;
      rd_st |=> (reg_rdata[0] | reg_rdata[2]) == $past(fault_irq);
   endproperty
   property p_clr; s_quiet ##0 rd_st |=> !fault_irq; endproperty
   property p_stop; $fell(en_r) |-> ##[1:3] !boost_on; endproperty
   property p_soft; $rose(boost_on) |-> s_ramp; endproperty
   property p_freq;
      reg_wr && reg_addr == 8'h02 |=> sw_freq_sel == $past(reg_wdata[4])
         && sample_rate_sel == $past(reg_wdata[6:5]);
   endproperty
   a_trip: assert property (p_trip)
      else $error("on after trip window");
   a_shut: assert property (p_shut)
      else $error("flag without shutdown");
   a_map: assert property (p_map)
      else $error("unmapped read not zero");
   a_flag: assert property (p_flag)
      else $error("flags disagree with irq");
   a_clr: assert property (p_clr)
      else $error("irq kept after read");
   a_stop: assert property (p_stop)
      else $error("converter not stopped");
   a_soft: assert property (p_soft)
      else $error("no soft start");
   a_freq: assert property (p_freq)
      else $error("freq or rate not stored");
endmodule // bpc_boost_ctrl_asserts

bind bpc_boost_ctrl bpc_boost_ctrl_asserts #(.FILT_CYC(FILT_CYC)) chk_inst (
   .clk, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
   .oc_cmp_in, .ov_cmp_in, .boost_on, .soft_start_lvl, .sw_freq_sel,
   .sample_rate_sel, .fault_irq);

// File: bpc_boost_ctrl_tb.sv
// bpc_boost_ctrl_tb.sv: self-checking bench of the boost converter control.
// assumes: short trip and recovery counts; 20 MHz clock.
`timescale 1ns/100ps
module bpc_boost_ctrl_tb;
   localparam int FILT = 20;
   localparam int REC  = 50;
   logic       clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
   logic       oc_cmp_in = 0, ov_cmp_in = 0;
   logic [7:0] reg_addr = 0, reg_wdata = 0;
   wire  [7:0] reg_rdata;
   wire  [3:0] soft_start_lvl, mic_bias_volts;
   wire  [1:0] sample_rate_sel;
   wire        boost_on, sw_freq_sel, mic_bias_on, fault_irq;
   int         err_total = 0, checked = 0, cyc = 0;
   always #25 clk = ~clk;
   bpc_boost_ctrl #(.FILT_CYC(FILT), .REC_CYC(REC)) bpc_boost_ctrl_inst (
      .clk, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
      .oc_cmp_in, .ov_cmp_in, .boost_on, .soft_start_lvl, .sw_freq_sel,
      .sample_rate_sel, .mic_bias_on, .mic_bias_volts, .fault_irq);
   // ======================================================================
   // shared tasks
   task automatic chk(string s, logic [7:0] got, logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", s, exp, got);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] exp, string s);
      @(posedge clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(s, reg_rdata, exp);
   endtask
   task automatic on_is(int n, logic [7:0] exp);
      repeat (n) @(posedge clk);
      #1 chk("on", boost_on, exp);
   endtask
   task automatic give_verdict;
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ======================================================================
   // scenarios
   task automatic t_regs;
      wr(8'h07, 8'hFF);
      #1 chk("on", boost_on, 8'h00);
      rd(8'h02, 8'h0A, "st");
      rd(8'h03, 8'h00, "ct");
      rd(8'h07, 8'h00, "bad");
      wr(8'h02, 8'hFF);
      rd(8'h02, 8'h7A, "st");
      chk("fsel", sw_freq_sel, 8'h01);
      chk("rate", sample_rate_sel, 8'h03);
      wr(8'h03, 8'hFA);
      rd(8'h03, 8'hF8, "ct");
      chk("bias", {mic_bias_volts, 3'b0, mic_bias_on}, 8'hF1);
      wr(8'h02, 8'h0A);
      wr(8'h03, 8'h00);
   endtask
   task automatic t_start;
      wr(8'h03, 8'h04);
      on_is(3, 8'h01);
      chk("lvl", soft_start_lvl, 8'h00);
      repeat (1500) @(posedge clk);
      #1 chk("lvl", soft_start_lvl, 8'h01);
      repeat (15000) @(posedge clk);
      #1 chk("lvl", soft_start_lvl, 8'h0F);
      wr(8'h03, 8'h00);
      on_is(3, 8'h00);
   endtask
   task automatic t_fault(bit is_ov, bit man);
      wr(8'h03, man ? 8'h05 : 8'h04);
      repeat (20) @(posedge clk);
      {oc_cmp_in, ov_cmp_in} <= {!is_ov, is_ov};
      on_is(FILT - 2, 8'h01);
      on_is(10, 8'h00);
      chk("irq", fault_irq, 8'h01);
      @(posedge clk);
      {oc_cmp_in, ov_cmp_in} <= 2'b00;
      rd(8'h02, is_ov ? 8'h0E : 8'h0B, "flag");
      chk("irq", fault_irq, 8'h00);
      on_is(15, 8'h00);
      if (man) begin
         on_is(60, 8'h00);
         wr(8'h03, 8'h07);
      end else begin
         on_is(REC - 26, 8'h00);
      end
      on_is(3, 8'h01);
   endtask
   task automatic t_persist;
      wr(8'h03, 8'h04);
      repeat (20) @(posedge clk);
      oc_cmp_in <= 1'b1;
      repeat (FILT - 5) @(posedge clk);
      oc_cmp_in <= 1'b0;
      @(posedge clk);
      oc_cmp_in <= 1'b1;
      on_is(FILT - 5, 8'h01);
      on_is(100, 8'h00);
      @(posedge clk);
      oc_cmp_in <= 1'b0;
      repeat (10) @(posedge clk);
      rd(8'h02, 8'h0B, "flag");
      chk("on", boost_on, 8'h01);
   endtask
   task automatic t_prot_off;
      wr(8'h02, 8'h02);
      ov_cmp_in <= 1'b1;
      on_is(FILT * 3, 8'h01);
      chk("irq", fault_irq, 8'h00);
      @(posedge clk);
      ov_cmp_in <= 1'b0;
      rd(8'h02, 8'h02, "st");
      wr(8'h02, 8'h0A);
   endtask
   task automatic t_reset;
      wr(8'h02, 8'h7A);
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      #1 chk("on", boost_on, 8'h00);
      chk("fsel", sw_freq_sel, 8'h00);
      chk("irq", fault_irq, 8'h00);
      rd(8'h02, 8'h0A, "st");
      rd(8'h03, 8'h00, "ct");
   endtask
   // ======================================================================
   // main sequence and hang guard
   initial begin
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      t_regs();
      t_start();
      t_fault(1'b0, 1'b0);
      t_fault(1'b1, 1'b1);
      t_persist();
      t_prot_off();
      t_reset();
      give_verdict();
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_total++;
         give_verdict();
      end
   end
endmodule // bpc_boost_ctrl_tb
